// *** logic/mmc_mode_config_regs.sv ***
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "mmc_consts.svh"

module mmc_mode_config_regs #(
  parameter bit HAS_REACTIVE = 1'b1
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write channels
  input  wire logic [17:0]         awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // axi4-lite read channels
  input  wire logic [17:0]         araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // measurement inputs
  input  wire logic                sample_valid,
  input  wire mmc_pkg::mmc_phase_t phase_current,
  input  wire logic [15:0]         neutral_current,
  input  wire mmc_pkg::mmc_phase_t phase_voltage,
  input  wire logic [2:0]          voltage_zero_cross,
  input  wire mmc_pkg::mmc_phase_t active_power,
  input  wire mmc_pkg::mmc_phase_t reactive_power,
  input  wire logic [7:0]          peak_window_cycles,
  // results
  output logic [35:0]              neutral_rms_result,
  output logic [17:0]              total_active_power,
  output logic [17:0]              total_reactive_power,
  output logic                     period_zero_cross,
  output logic [15:0]              voltage_peak,
  output logic [15:0]              current_peak,
  output logic                     peak_window_done,
  output logic [31:0]              active_energy,
  output logic [31:0]              reactive_energy,
  output logic [1:0]               energy_pulse_output
);

  // ******************************************************
  // helpers
  // ******************************************************
  function automatic mmc_pkg::mmc_sel_t decode(input logic [17:0] addr);
    case (addr)
      {`MMC_IDX_MEAS_MODE, 2'b00}:  return mmc_pkg::MMC_SEL_MEAS;
      {`MMC_IDX_ACCUM_MODE, 2'b00}: return mmc_pkg::MMC_SEL_ACCUM;
      {`MMC_IDX_STATUS, 2'b00}:     return mmc_pkg::MMC_SEL_STATUS;
      {`MMC_IDX_AUX, 2'b00}:        return mmc_pkg::MMC_SEL_AUX;
      default:                      return mmc_pkg::MMC_SEL_NONE;
    endcase
  endfunction

  function automatic logic signed [17:0] ext(input logic [15:0] v);
    return 18'($signed(v));
  endfunction
  function automatic logic signed [17:0] sum3(input mmc_pkg::mmc_phase_t p);
    return ext(p.a) + ext(p.b) + ext(p.c);
  endfunction
  function automatic logic signed [17:0] abs18(input logic signed [17:0] v);
    return (v < 0) ? -v : v;
  endfunction
  function automatic logic [1:0] ones3(input logic [2:0] v);
    return 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction
  function automatic logic [15:0] max16(input logic [15:0] x,
                                        input logic [15:0] y);
    return (x > y) ? x : y;
  endfunction

  function automatic logic signed [17:0] react_term(
      input logic [1:0]  mode,
      input logic [15:0] p,
      input logic [15:0] q);
    case (mode)
      2'b10:   return p[15] ? -ext(q) : ext(q);
      2'b11:   return abs18(ext(q));
      default: return ext(q);
    endcase
  endfunction

  localparam mmc_pkg::mmc_state_t ST_RST = '{
    aw_rdy:     1'b1,
    w_rdy:      1'b1,
    ar_rdy:     1'b1,
    meas_mode:  `MMC_RST_MEAS_MODE,
    accum_mode: `MMC_RST_ACCUM_MODE,
    aux:        `MMC_RST_AUX,
    bresp:      mmc_pkg::MMC_RESP_OKAY,
    rresp:      mmc_pkg::MMC_RESP_OKAY,
    default:    '0
  };

  mmc_pkg::mmc_state_t st, next_st;
  mmc_pkg::mmc_sel_t   wsel, rsel;
  logic                wr_fire;
  logic [1:0]          per_eff;
  logic [2:0]          peak_en;
  logic [1:0]          act_mode, react_mode;
  logic signed [17:0]  act_sum, react_sum;
  logic signed [17:0]  act_pulse_in, react_pulse_in;
  logic signed [35:0]  sq;
  logic signed [36:0]  ms_diff;
  logic signed [31:0]  acc_a, acc_r;
  logic [8:0]          cnt_new;
  logic [8:0]          win;
  logic [15:0]         vmax, imax;

  // ******************************************************
  // next state
  // ******************************************************
  always_comb begin
    next_st        = st;
    next_st.pulse  = 2'b00;
    next_st.peak_done = 1'b0;
    wsel           = decode(st.aw_addr);
    rsel           = decode(araddr);
    wr_fire        = st.aw_held && st.w_held && !st.bvalid;
    per_eff        = st.meas_mode[`MMC_MM_PER_LSB +: 2];
    if (per_eff == 2'b11) begin
      per_eff = 2'b00;
    end
    peak_en        = st.meas_mode[`MMC_MM_PEAK_LSB +: 3];
    act_mode       = st.accum_mode[`MMC_ACC_ACT_LSB +: 2];
    react_mode     = st.accum_mode[`MMC_ACC_REACT_LSB +: 2];
    act_sum        = sum3(active_power);
    react_sum      = sum3(reactive_power);
    if (act_mode == 2'b11) begin
      act_pulse_in = abs18(ext(active_power.a)) + abs18(ext(active_power.b))
                     + abs18(ext(active_power.c));
    end else begin
      act_pulse_in = act_sum;
    end
    react_pulse_in = react_term(react_mode, active_power.a, reactive_power.a)
                   + react_term(react_mode, active_power.b, reactive_power.b)
                   + react_term(react_mode, active_power.c, reactive_power.c);
    sq             = st.nsrc * st.nsrc;
    ms_diff        = $signed({1'b0, sq}) - $signed({1'b0, st.ms});
    acc_a          = st.act_acc + 32'(act_pulse_in);
    acc_r          = st.react_acc + 32'(react_pulse_in);
    cnt_new        = 9'(st.peak_cnt) + 9'(ones3(voltage_zero_cross & peak_en));
    win            = (peak_window_cycles == 8'h00) ? 9'h001
                                                   : 9'(peak_window_cycles);
    vmax           = st.vpeak_run;
    imax           = st.ipeak_run;

    // write channels, taken in either order
    if (awvalid && st.aw_rdy) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && st.w_rdy) begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = wdata[7:0];
      next_st.w_lane0 = wstrb[0];
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = (wsel == mmc_pkg::MMC_SEL_NONE)
                        ? mmc_pkg::MMC_RESP_SLVERR : mmc_pkg::MMC_RESP_OKAY;
      if (st.w_lane0) begin
        case (wsel)
          mmc_pkg::MMC_SEL_MEAS:  next_st.meas_mode = st.w_data;
          mmc_pkg::MMC_SEL_ACCUM: begin
            next_st.accum_mode = st.w_data;
            if (!HAS_REACTIVE) begin
              next_st.accum_mode[`MMC_ACC_REACT_LSB +: 2] = 2'b00;
            end
          end
          mmc_pkg::MMC_SEL_AUX:   next_st.aux = st.w_data;
          default: begin
          end
        endcase
      end
    end
    next_st.aw_rdy = !next_st.aw_held;
    next_st.w_rdy  = !next_st.w_held;

    // read channels
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
      next_st.ar_rdy = 1'b1;
    end
    if (arvalid && st.ar_rdy) begin
      next_st.ar_rdy = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp  = mmc_pkg::MMC_RESP_OKAY;
      case (rsel)
        mmc_pkg::MMC_SEL_MEAS:   next_st.rdata = {24'h000000, st.meas_mode};
        mmc_pkg::MMC_SEL_ACCUM:  next_st.rdata = {24'h000000, st.accum_mode};
        mmc_pkg::MMC_SEL_AUX:    next_st.rdata = {24'h000000, st.aux};
        mmc_pkg::MMC_SEL_STATUS: next_st.rdata = {24'h000000, 3'h0,
                                   react_mode, act_mode == 2'b11, per_eff};
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = mmc_pkg::MMC_RESP_SLVERR;
        end
      endcase
    end

    // period source
    next_st.period_zx = voltage_zero_cross[per_eff];

    // measurement path, reserved bits are never looked at
    if (sample_valid) begin
      if (st.aux[`MMC_AUX_NSRC_BIT]) begin
        next_st.nsrc = sum3(phase_current);
      end else begin
        next_st.nsrc = ext(neutral_current);
      end
      next_st.ms = 36'($signed({1'b0, st.ms}) + (ms_diff >>> `MMC_MS_SHIFT));
      next_st.filt_act   = st.filt_act
                         + 18'((act_sum - st.filt_act) >>> `MMC_FILT_SHIFT);
      next_st.filt_react = st.filt_react
                         + 18'((react_sum - st.filt_react) >>> `MMC_FILT_SHIFT);
      if (st.aux[`MMC_AUX_FILT_BIT]) begin
        next_st.tot_act   = next_st.filt_act;
        next_st.tot_react = next_st.filt_react;
      end else begin
        next_st.tot_act   = act_sum;
        next_st.tot_react = react_sum;
      end
      next_st.act_energy   = st.act_energy + 32'(act_sum);
      next_st.react_energy = st.react_energy + 32'(react_sum);

      // energy to frequency converters
      if (acc_a >= $signed(`MMC_PULSE_THRESH)) begin
        next_st.act_acc  = acc_a - $signed(`MMC_PULSE_THRESH);
        next_st.pulse[0] = 1'b1;
      end else if (acc_a <= -$signed(`MMC_PULSE_THRESH)) begin
        next_st.act_acc  = acc_a + $signed(`MMC_PULSE_THRESH);
        next_st.pulse[0] = 1'b1;
      end else begin
        next_st.act_acc  = acc_a;
      end
      if (acc_r >= $signed(`MMC_PULSE_THRESH)) begin
        next_st.react_acc = acc_r - $signed(`MMC_PULSE_THRESH);
        next_st.pulse[1]  = 1'b1;
      end else if (acc_r <= -$signed(`MMC_PULSE_THRESH)) begin
        next_st.react_acc = acc_r + $signed(`MMC_PULSE_THRESH);
        next_st.pulse[1]  = 1'b1;
      end else begin
        next_st.react_acc = acc_r;
      end

      // running peaks over every enabled phase
      if (peak_en[0]) begin
        vmax = max16(vmax, 16'(abs18(ext(phase_voltage.a))));
        imax = max16(imax, 16'(abs18(ext(phase_current.a))));
      end
      if (peak_en[1]) begin
        vmax = max16(vmax, 16'(abs18(ext(phase_voltage.b))));
        imax = max16(imax, 16'(abs18(ext(phase_current.b))));
      end
      if (peak_en[2]) begin
        vmax = max16(vmax, 16'(abs18(ext(phase_voltage.c))));
        imax = max16(imax, 16'(abs18(ext(phase_current.c))));
      end
      next_st.vpeak_run = vmax;
      next_st.ipeak_run = imax;
    end

    // window closes once the count of crossings on enabled phases reaches peak_window_cycles, or 1 when peak_window_cycles is 0
    if (cnt_new >= win) begin
      next_st.peak_done = 1'b1;
      next_st.peak_cnt  = 8'h00;
      next_st.vpeak     = next_st.vpeak_run;
      next_st.ipeak     = next_st.ipeak_run;
      next_st.vpeak_run = 16'h0000;
      next_st.ipeak_run = 16'h0000;
    end else begin
      next_st.peak_cnt  = cnt_new[7:0];
    end
  end

  // ******************************************************
  // state register
  // ******************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign awready              = st.aw_rdy;
  assign wready               = st.w_rdy;
  assign bvalid               = st.bvalid;
  assign bresp                = st.bresp;
  assign arready              = st.ar_rdy;
  assign rvalid               = st.rvalid;
  assign rresp                = st.rresp;
  assign rdata                = st.rdata;
  assign neutral_rms_result   = st.ms;
  assign total_active_power   = st.tot_act;
  assign total_reactive_power = st.tot_react;
  assign period_zero_cross    = st.period_zx;
  assign voltage_peak         = st.vpeak;
  assign current_peak         = st.ipeak;
  assign peak_window_done     = st.peak_done;
  assign active_energy        = st.act_energy;
  assign reactive_energy      = st.react_energy;
  assign energy_pulse_output  = st.pulse;

  // ******************************************************
  // assertions
  // ******************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_meas_write;
    wr_fire && st.w_lane0 && wsel == mmc_pkg::MMC_SEL_MEAS;
  endsequence

  sequence s_meas_answer;
    bvalid && bresp == 2'b00 && st.meas_mode == $past(st.w_data);
  endsequence

  a_write_read_back: assert property (s_meas_write |=> s_meas_answer)
    else $error("written mode value not stored");

  a_period_code_fold: assert property (
    st.meas_mode[1:0] == 2'b11 |=>
      period_zero_cross == $past(voltage_zero_cross[0]))
    else $error("code 11 does not follow phase A");

  a_period_phase_b: assert property (
    st.meas_mode[1:0] == 2'b01 |=>
      period_zero_cross == $past(voltage_zero_cross[1]))
    else $error("code 01 does not follow phase B");

  a_neutral_from_sum: assert property (
    sample_valid && st.aux[0] |=> st.nsrc == $past(sum3(phase_current)))
    else $error("neutral source is not the phase sum");

  a_neutral_measured: assert property (
    sample_valid && !st.aux[0] |=> st.nsrc == $past(ext(neutral_current)))
    else $error("neutral source is not the neutral current");

  a_filter_bypass: assert property (
    sample_valid && !st.aux[1] |=>
      total_active_power == $past(sum3(active_power)))
    else $error("unfiltered total power wrong");

  a_energy_stays_signed: assert property (
    sample_valid && st.accum_mode[1:0] == 2'b11 |=>
      active_energy == 32'($past(active_energy) + $past(32'(act_sum))))
    else $error("active energy not signed in absolute mode");

  a_reactive_fixed: assert property (
    HAS_REACTIVE || st.accum_mode[3:2] == 2'b00)
    else $error("reactive mode left nonzero");

  a_peak_reset_value: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> st.meas_mode[4:2] == 3'b111)
    else $error("peak enables not set after reset");

  a_peak_window_end: assert property (
    cnt_new >= win |=> peak_window_done && st.peak_cnt == 8'h00)
    else $error("peak window did not close");

endmodule // mmc_mode_config_regs

// *** include/mmc_consts.svh ***
`ifndef MMC_CONSTS_SVH
`define MMC_CONSTS_SVH

// Notes on behaviour
// - neutral source bit 0: neutral result tracks the measured neutral current
// - neutral source bit 1: neutral result tracks sum of three phase currents
// - extra filter bit 1: total active and reactive power get low-pass filter
// - period phase field 00, 01, 10 picks phase A, B, C
// - period phase code 11 behaves exactly like code 00
// - peak enable bits 2, 3, 4 include phases A, B, C; reset to 1
// - all three peak enable bits may be set together
// - zero crossings of every enabled phase count toward the peak window
// - active mode 00 accumulates active power with sign
// - active modes 01 and 10 behave like 00
// - active mode 11 accumulates absolute values, for the pulse output only
// - active energy registers stay signed whatever the mode
// - reactive mode 00 accumulates reactive power with sign
// - without reactive measurement the reactive mode field stays 00
// - reactive mode 01 behaves like 00
// - reserved bits have no effect on behaviour
// - pulse outputs come from energy-to-frequency converters fed by mode

// ******************************************************
// register indices; byte address is four times the index
// ******************************************************
`define MMC_IDX_MEAS_MODE  16'hE700
`define MMC_IDX_ACCUM_MODE 16'hE701
`define MMC_IDX_STATUS     16'hE702
`define MMC_IDX_AUX        16'hE740

// ******************************************************
// reset values
// ******************************************************
`define MMC_RST_MEAS_MODE  8'h1C
`define MMC_RST_ACCUM_MODE 8'h00
`define MMC_RST_AUX        8'h00

// ******************************************************
// field positions
// ******************************************************
`define MMC_AUX_NSRC_BIT   0
`define MMC_AUX_FILT_BIT   1
`define MMC_MM_PER_LSB     0
`define MMC_MM_PEAK_LSB    2
`define MMC_ACC_ACT_LSB    0
`define MMC_ACC_REACT_LSB  2

// ******************************************************
// arithmetic constants
// ******************************************************
`define MMC_FILT_SHIFT     3
`define MMC_MS_SHIFT       6
`define MMC_PULSE_THRESH   32'h0010_0000

`endif

// *** include/mmc_pkg.sv ***
package mmc_pkg;

  // three phase samples
  typedef struct packed {
    logic [15:0] c;
    logic [15:0] b;
    logic [15:0] a;
  } mmc_phase_t;

  // axi4-lite read and write responses
  typedef enum logic [1:0] {
    MMC_RESP_OKAY   = 2'b00,
    MMC_RESP_SLVERR = 2'b10
  } mmc_resp_t;

  // register selection decoded from an address
  typedef enum logic [2:0] {
    MMC_SEL_NONE,
    MMC_SEL_MEAS,
    MMC_SEL_ACCUM,
    MMC_SEL_STATUS,
    MMC_SEL_AUX
  } mmc_sel_t;

  // complete state of the block
  typedef struct packed {
    logic               aw_held;
    logic [17:0]        aw_addr;
    logic               w_held;
    logic [7:0]         w_data;
    logic               w_lane0;
    logic               aw_rdy;
    logic               w_rdy;
    logic               bvalid;
    mmc_resp_t          bresp;
    logic               ar_rdy;
    logic               rvalid;
    mmc_resp_t          rresp;
    logic [31:0]        rdata;
    logic [7:0]         meas_mode;
    logic [7:0]         accum_mode;
    logic [7:0]         aux;
    logic signed [17:0] nsrc;
    logic [35:0]        ms;
    logic signed [17:0] filt_act;
    logic signed [17:0] filt_react;
    logic signed [17:0] tot_act;
    logic signed [17:0] tot_react;
    logic               period_zx;
    logic [15:0]        vpeak_run;
    logic [15:0]        ipeak_run;
    logic [15:0]        vpeak;
    logic [15:0]        ipeak;
    logic [7:0]         peak_cnt;
    logic               peak_done;
    logic signed [31:0] act_energy;
    logic signed [31:0] react_energy;
    logic signed [31:0] act_acc;
    logic signed [31:0] react_acc;
    logic [1:0]         pulse;
  } mmc_state_t;

endpackage

// *** verif/mmc_mode_config_regs_tb_top.sv ***
`timescale 1ns/100ps
module mmc_mode_config_regs_tb_top;
  // ****************
  // signals and design
  // ****************
  typedef struct packed {
    logic [17:0] addr;
    logic [7:0]  rst;
    logic [7:0]  wd;
    logic [7:0]  exp;
    logic [1:0]  resp;
  } mmc_row_t;

  logic                aclk;
  logic                aresetn;
  logic [17:0]         awaddr;
  logic [17:0]         araddr;
  logic                awvalid;
  logic                wvalid;
  logic                bready;
  logic                arvalid;
  logic                rready;
  logic [31:0]         wdata;
  logic [3:0]          wstrb;
  logic                awready;
  logic                wready;
  logic                bvalid;
  logic                arready;
  logic                rvalid;
  logic [1:0]          bresp;
  logic [1:0]          rresp;
  logic [31:0]         rdata;
  logic [31:0]         act_e;
  logic [31:0]         react_e;
  logic [31:0]         rdata_nr;
  logic [17:0]         tot_r;
  logic [15:0]         vpk;
  logic [15:0]         ipk;
  logic                sample_valid;
  logic                pzc;
  logic                pdone;
  mmc_pkg::mmc_phase_t cur;
  mmc_pkg::mmc_phase_t actp;
  logic [15:0]         ncur;
  logic [2:0]          zc;
  logic [7:0]          pwin;
  logic [35:0]         nrms;
  logic [17:0]         tot_a;
  logic [1:0]          pulse;
  logic                filt;
  logic [31:0]         exp_e;
  logic [31:0]         got;
  logic [1:0]          resp;
  int                  num_errors;
  int                  n_checks;
  int                  n_done;
  int                  n_pulse;
  int                  snap;
  mmc_row_t            rows [9];

  mmc_mode_config_regs DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sample_valid(sample_valid), .phase_current(cur),
    .neutral_current(ncur), .phase_voltage(cur), .voltage_zero_cross(zc),
    .active_power(actp), .reactive_power(actp), .peak_window_cycles(pwin),
    .neutral_rms_result(nrms), .total_active_power(tot_a),
    .total_reactive_power(tot_r), .period_zero_cross(pzc),
    .voltage_peak(vpk), .current_peak(ipk), .peak_window_done(pdone),
    .active_energy(act_e), .reactive_energy(react_e),
    .energy_pulse_output(pulse)
  );

  // variant without reactive measurement, in lockstep on the same bus
  mmc_mode_config_regs #(.HAS_REACTIVE(1'b0)) DUT_NR (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(), .bresp(), .bvalid(), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(rdata_nr),
    .rresp(), .rvalid(), .rready(rready),
    .sample_valid(sample_valid), .phase_current(cur),
    .neutral_current(ncur), .phase_voltage(cur), .voltage_zero_cross(zc),
    .active_power(actp), .reactive_power(actp), .peak_window_cycles(pwin),
    .neutral_rms_result(), .total_active_power(),
    .total_reactive_power(), .period_zero_cross(), .voltage_peak(),
    .current_peak(), .peak_window_done(), .active_energy(),
    .reactive_energy(), .energy_pulse_output()
  );

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [35:0] g, input logic [35:0] e,
                     input string m);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic aw_p;
    logic w_p;
    @(posedge aclk);
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      aw_p = aw_p && !awready;
      w_p = w_p && !wready;
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic smp(input int a, input int b, input int c);
    @(posedge aclk);
    actp <= {16'(c), 16'(b), 16'(a)};
    cur <= {16'(c), 16'(b), 16'(a)};
    sample_valid <= 1'b1;
    @(posedge aclk);
    sample_valid <= 1'b0;
    exp_e = exp_e + 32'(a + b + c);
    #1;
    chk({4'h0, act_e}, {4'h0, exp_e}, "energy");
    if (!filt) chk({18'h0, tot_a}, {18'h0, 18'(a + b + c)}, "total");
    chk({4'h0, react_e}, {4'h0, exp_e}, "reactive energy");
    if (!filt) chk({18'h0, tot_r}, {18'h0, 18'(a + b + c)}, "tr");
  endtask

  task automatic zcp(input logic [2:0] v);
    @(posedge aclk);
    zc <= v;
    @(posedge aclk);
    zc <= 3'h0;
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************
  // clock, monitor, watchdog
  // ****************
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (pdone === 1'b1) n_done <= n_done + 1;
    if (pulse[0] === 1'b1) n_pulse <= n_pulse + 1;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    final_report();
  end

  // ****************
  // tests
  // ****************
  initial begin
    rows = '{'{18'h39C00, 8'h1C, 8'hFF, 8'hFF, 2'h0},
             '{18'h39C04, 8'h00, 8'hA5, 8'hA5, 2'h0},
             '{18'h39D00, 8'h00, 8'hFE, 8'hFE, 2'h0},
             '{18'h39C08, 8'h00, 8'h55, 8'h08, 2'h0},
             '{18'h39C0C, 8'h00, 8'h77, 8'h00, 2'h2},
             '{18'h39C04, 8'h00, 8'h03, 8'h03, 2'h0},
             '{18'h39C08, 8'h00, 8'h00, 8'h04, 2'h0},
             '{18'h39C00, 8'h1C, 8'h1E, 8'h1E, 2'h0},
             '{18'h39C08, 8'h00, 8'h00, 8'h06, 2'h0}};
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, sample_valid} = '0;
    wstrb = 4'hF;
    cur = '0;
    actp = '0;
    ncur = 16'h0;
    zc = 3'h0;
    pwin = 8'h03;
    filt = 1'b0;
    exp_e = 32'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].addr, got, resp);
      chk({4'h0, got}, {28'h0, rows[i].rst}, "reset value");
    end
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wd, resp);
      chk({34'h0, resp}, {34'h0, rows[i].resp}, "bresp");
      rd(rows[i].addr, got, resp);
      chk({4'h0, got}, {28'h0, rows[i].exp}, "read");
      chk({34'h0, resp}, {34'h0, rows[i].resp}, "rresp");
    end
    wr(18'h39C04, 8'h0C, resp);
    rd(18'h39C04, got, resp);
    chk({4'h0, got}, 36'h0C, "reactive mode");
    chk({4'h0, rdata_nr}, 36'h0, "fixed reactive mode");
    for (int k = 0; k < 4; k++) begin
      wr(18'h39C00, 8'(8'h1C | k), resp);
      @(posedge aclk);
      zc <= 3'(1 << ((k == 3) ? 0 : k));
      @(posedge aclk);
      zc <= ~zc;
      #1;
      chk({35'h0, pzc}, 36'h1, "period phase hit");
      @(posedge aclk);
      zc <= 3'h0;
      #1;
      chk({35'h0, pzc}, 36'h0, "period phase miss");
    end
    wr(18'h39D00, 8'h00, resp);
    wr(18'h39C04, 8'h00, resp);
    smp(1000, -3000, 500);
    smp(-20000, -20000, -20000);
    chk(nrms, 36'h0, "neutral source");
    wr(18'h39C04, 8'h03, resp);
    snap = n_pulse;
    repeat (14) smp(30000, -30000, 30000);
    chk({35'h0, n_pulse > snap}, 36'h1, "absolute pulses");
    wr(18'h39D00, 8'h01, resp);
    repeat (2) smp(1000, 1000, 1000);
    chk({35'h0, nrms != 36'h0}, 36'h1, "phase sum source");
    wr(18'h39D00, 8'h03, resp);
    filt = 1'b1;
    smp(9000, 9000, 9000);
    chk({35'h0, tot_a != 18'(27000)}, 36'h1, "extra filter");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(18'h39C00, got, resp);
    chk({4'h0, got}, 36'h1C, "reset again");
    chk({4'h0, act_e}, 36'h0, "energy reset");
    exp_e = 32'h0;
    wr(18'h39C00, 8'h04, resp);
    snap = n_done;
    repeat (2) zcp(3'h7);
    repeat (3) @(posedge aclk);
    chk(36'(n_done - snap), 36'h0, "one phase window");
    smp(100, -200, 300);
    wr(18'h39C00, 8'h1C, resp);
    zcp(3'h7);
    repeat (3) @(posedge aclk);
    chk({35'h0, n_done > snap}, 36'h1, "three phase window");
    chk({20'h0, vpk}, 36'h64, "voltage peak");
    chk({20'h0, ipk}, 36'h64, "current peak");
    final_report();
  end
endmodule // mmc_mode_config_regs_tb_top
